// ==== design/scprs_top.sv ====
// Serial config port with requantizer and sync control registers
`timescale 1ns/10ps
`include "scprs_consts.svh"
module scprs_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic spi_sclk,
   input wire logic chip_select_n,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   input wire logic sync_in,
   output logic strap_mode,
   output scprs_pkg::scprs_chan_t chan_a_cfg,
   output scprs_pkg::scprs_chan_t chan_b_cfg,
   output logic chan_a_tune_ok,
   output logic chan_b_tune_ok,
   output logic [8:0] chan_a_left_edge,
   output logic [8:0] chan_b_left_edge,
   output logic div_resync
);
   localparam scprs_pkg::scprs_state_t RST = '{
      st: scprs_pkg::scprs_st_idle,
      cfg: `SCPRS_RST_CFG,
      chidx: `SCPRS_RST_CHIDX,
      armed: 1'b1,
      default: '0
   };

   scprs_pkg::scprs_state_t r_reg;
   scprs_pkg::scprs_state_t r_next;
   logic sclk_lvl;
   logic csb_lvl;
   logic sdio_lvl;
   logic sync_lvl;
   logic sclk_rise;
   logic sclk_fall;
   logic lsb;
   logic [15:0] instr_word;
   logic [7:0] byte_in;
   logic [7:0] next_addr;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic sync_evt;
   logic first_only;

   // Pins from outside the clock domain all pass the same filter
   scprs_sync3 #(.RESET_LVL(1'b0)) u_sclk (.ref_clk(ref_clk), .nrst(nrst), .d(spi_sclk), .q(sclk_lvl));
   scprs_sync3 #(.RESET_LVL(1'b1)) u_csb (.ref_clk(ref_clk), .nrst(nrst), .d(chip_select_n), .q(csb_lvl));
   scprs_sync3 #(.RESET_LVL(1'b0)) u_sdio (.ref_clk(ref_clk), .nrst(nrst), .d(sdio_i), .q(sdio_lvl));
   scprs_sync3 #(.RESET_LVL(1'b0)) u_sync (.ref_clk(ref_clk), .nrst(nrst), .d(sync_in), .q(sync_lvl));

   // Readback mux; channel A wins when both index bits are set
   function automatic logic [7:0] rd_mux(input scprs_pkg::scprs_state_t s, input logic [7:0] a);
      scprs_pkg::scprs_chan_t c;
      c = s.chidx[`SCPRS_B_CH_A] ? s.sh_a : s.sh_b;
      case (a)
         `SCPRS_A_CFG: rd_mux = s.cfg;
         `SCPRS_A_CHIDX: rd_mux = s.chidx;
         `SCPRS_A_DIVSYNC: rd_mux = s.sh_divsync;
         `SCPRS_A_NSRCTL: rd_mux = {4'h0, c.mode, c.enable};
         `SCPRS_A_TUNE: rd_mux = {2'h0, c.word};
         `SCPRS_A_SYNCMODE: rd_mux = s.sh_syncmode;
         `SCPRS_A_XFER: rd_mux = {7'h00, s.xfer};
         default: rd_mux = 8'h00;
      endcase
   endfunction

   // Band position check against the mode's count of legal words
   function automatic logic tune_ok(input scprs_pkg::scprs_chan_t c);
      case (c.mode)
         `SCPRS_MODE_NARROW: tune_ok = (c.word < `SCPRS_TW_NARROW_CNT);
         `SCPRS_MODE_WIDE: tune_ok = (c.word < `SCPRS_TW_WIDE_CNT);
         default: tune_ok = 1'b0;
      endcase
   endfunction

   // Frame engine, register file, transfer and sync logic
   always_comb begin
      r_next = r_reg;
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      sclk_rise = sclk_lvl & ~r_reg.sclk_prev;
      sclk_fall = ~sclk_lvl & r_reg.sclk_prev;
      lsb = r_reg.cfg[`SCPRS_B_LSB_FIRST];
      instr_word = {r_reg.shift[14:0], sdio_lvl};
      byte_in = lsb ? {sdio_lvl, r_reg.shift[7:1]} : {r_reg.shift[6:0], sdio_lvl};
      next_addr = lsb ? r_reg.addr + 8'h01 : r_reg.addr - 8'h01;
      r_next.sclk_prev = sclk_lvl;
      r_next.sync_prev = sync_lvl;
      r_next.div_resync = 1'b0;
      // Strap flag holds only until the first clocked frame
      r_next.strap_mode = csb_lvl & ~r_reg.seen_frame;
      if (csb_lvl) begin
         // Select high: driver off; a pause is legal only on a byte boundary
         r_next.sdio_oe = 1'b0;
         if (r_reg.st == scprs_pkg::scprs_st_instr || r_reg.bit_cnt != 4'h0 || r_reg.stream) begin
            r_next.st = scprs_pkg::scprs_st_idle;
            r_next.bit_cnt = 4'h0;
         end
      end else if (sclk_rise) begin
         r_next.seen_frame = 1'b1;
         case (r_reg.st)
            scprs_pkg::scprs_st_idle: begin
               r_next.shift = {15'h0000, sdio_lvl};
               r_next.bit_cnt = 4'h1;
               r_next.st = scprs_pkg::scprs_st_instr;
            end
            scprs_pkg::scprs_st_instr: begin
               r_next.shift = instr_word;
               r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               if (r_reg.bit_cnt == `SCPRS_INSTR_LAST) begin
                  r_next.is_read = instr_word[`SCPRS_B_RW];
                  r_next.stream = (instr_word[`SCPRS_F_WLEN] == `SCPRS_WLEN_STREAM);
                  r_next.bytes_left = instr_word[`SCPRS_F_WLEN];
                  r_next.addr = instr_word[`SCPRS_F_ADDR];
                  r_next.rd_byte = rd_mux(r_reg, instr_word[`SCPRS_F_ADDR]);
                  r_next.bit_cnt = 4'h0;
                  r_next.st = scprs_pkg::scprs_st_data;
               end
            end
            scprs_pkg::scprs_st_data: begin
               r_next.shift[7:0] = byte_in;
               r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               if (r_reg.bit_cnt == `SCPRS_BYTE_LAST) begin
                  // Byte complete: commit a write, step the address, count down
                  r_next.bit_cnt = 4'h0;
                  wr_en = ~r_reg.is_read;
                  wr_addr = r_reg.addr;
                  wr_data = byte_in;
                  r_next.addr = next_addr;
                  r_next.rd_byte = rd_mux(r_reg, next_addr);
                  if (!r_reg.stream) begin
                     if (r_reg.bytes_left == 2'h0) begin
                        r_next.st = scprs_pkg::scprs_st_idle;
                        r_next.sdio_oe = 1'b0;
                     end else begin
                        r_next.bytes_left = r_reg.bytes_left - 2'h1;
                     end
                  end
               end
            end
            default: begin
               r_next.st = scprs_pkg::scprs_st_idle;
               r_next.bit_cnt = 4'h0;
            end
         endcase
      end else if ((sclk_fall || (!sclk_lvl && !r_reg.sdio_oe)) && r_reg.st == scprs_pkg::scprs_st_data
                   && r_reg.is_read) begin
         // Readback bits change on the fall, or on resuming after a pause, so the host samples on the rise
         r_next.sdio_oe = 1'b1;
         r_next.sdio_out = r_reg.rd_byte[lsb ? r_reg.bit_cnt[2:0] : `SCPRS_BIT_TOP - r_reg.bit_cnt[2:0]];
      end
      // Transfer copies every shadow at once, then the bit drops
      if (r_reg.xfer) begin
         r_next.act_a = r_reg.sh_a;
         r_next.act_b = r_reg.sh_b;
         r_next.act_divsync = r_reg.sh_divsync;
         r_next.act_syncmode = r_reg.sh_syncmode;
         r_next.armed = 1'b1;
         r_next.xfer = 1'b0;
      end
      // Register writes; a new transfer request beats the self-clear
      if (wr_en) begin
         case (wr_addr)
            `SCPRS_A_CFG: r_next.cfg = wr_data;
            `SCPRS_A_CHIDX: r_next.chidx = wr_data;
            `SCPRS_A_DIVSYNC: r_next.sh_divsync = wr_data;
            `SCPRS_A_SYNCMODE: r_next.sh_syncmode = wr_data;
            `SCPRS_A_NSRCTL: begin
               if (r_reg.chidx[`SCPRS_B_CH_A]) begin
                  r_next.sh_a.mode = wr_data[`SCPRS_F_MODE];
                  r_next.sh_a.enable = wr_data[`SCPRS_B_NSR_EN];
               end
               if (r_reg.chidx[`SCPRS_B_CH_B]) begin
                  r_next.sh_b.mode = wr_data[`SCPRS_F_MODE];
                  r_next.sh_b.enable = wr_data[`SCPRS_B_NSR_EN];
               end
            end
            `SCPRS_A_TUNE: begin
               if (r_reg.chidx[`SCPRS_B_CH_A]) begin
                  r_next.sh_a.word = wr_data[`SCPRS_F_WORD];
               end
               if (r_reg.chidx[`SCPRS_B_CH_B]) begin
                  r_next.sh_b.word = wr_data[`SCPRS_F_WORD];
               end
            end
            `SCPRS_A_XFER: begin
               if (wr_data == `SCPRS_XFER_CMD) begin
                  r_next.xfer = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // Sync qualification: level, or chosen edge of the filtered input
      if (r_reg.act_syncmode[`SCPRS_B_SYNC_EDGE]) begin
         sync_evt = r_reg.act_syncmode[`SCPRS_B_SYNC_FALL] ? (~sync_lvl & r_reg.sync_prev)
                                                            : (sync_lvl & ~r_reg.sync_prev);
      end else begin
         sync_evt = sync_lvl;
      end
      first_only = r_reg.act_divsync[`SCPRS_B_SYNC_FIRST];
      if (r_reg.act_divsync[`SCPRS_B_SYNC_EN] && sync_evt && (!first_only || r_reg.armed)) begin
         r_next.div_resync = 1'b1;
         if (first_only) begin
            r_next.armed = 1'b0;
         end
      end
      // Band checks lag the active settings by one cycle
      r_next.ok_a = tune_ok(r_reg.act_a);
      r_next.ok_b = tune_ok(r_reg.act_b);
      r_next.edge_a = {3'h0, r_reg.act_a.word} * `SCPRS_EDGE_STEP;
      r_next.edge_b = {3'h0, r_reg.act_b.word} * `SCPRS_EDGE_STEP;
   end

   // Single state register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sdio_o = r_reg.sdio_out;
   assign sdio_oe = r_reg.sdio_oe;
   assign strap_mode = r_reg.strap_mode;
   assign chan_a_cfg = r_reg.act_a;
   assign chan_b_cfg = r_reg.act_b;
   assign chan_a_tune_ok = r_reg.ok_a;
   assign chan_b_tune_ok = r_reg.ok_b;
   assign chan_a_left_edge = r_reg.edge_a;
   assign chan_b_left_edge = r_reg.edge_b;
   assign div_resync = r_reg.div_resync;

   // Checks on the design's own outputs and state
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   property p_oe_off_csb_high;
      csb_lvl |=> !sdio_oe;
   endproperty
   a_oe_off_csb_high: assert property (p_oe_off_csb_high) else $error("driver on with select high");

   property p_oe_only_read;
      sdio_oe |-> r_reg.is_read && r_reg.st == scprs_pkg::scprs_st_data;
   endproperty
   a_oe_only_read: assert property (p_oe_only_read) else $error("driver on outside read data");

   property p_strap_hiz;
      strap_mode |-> !sdio_oe;
   endproperty
   a_strap_hiz: assert property (p_strap_hiz) else $error("driver on in strap mode");

   property p_idle_holds;
      csb_lvl && r_reg.st == scprs_pkg::scprs_st_idle |=> r_reg.st == scprs_pkg::scprs_st_idle;
   endproperty
   a_idle_holds: assert property (p_idle_holds) else $error("frame opened with select high");

   property p_instr_len;
      $rose(r_reg.st == scprs_pkg::scprs_st_data) |-> $past(r_reg.bit_cnt) == `SCPRS_INSTR_LAST;
   endproperty
   a_instr_len: assert property (p_instr_len) else $error("instruction not sixteen bits");

   property p_xfer_clear;
      r_reg.xfer && !wr_en |=> !r_reg.xfer;
   endproperty
   a_xfer_clear: assert property (p_xfer_clear) else $error("transfer bit stuck");

   property p_act_on_xfer;
      $changed(chan_a_cfg) |-> $past(r_reg.xfer);
   endproperty
   a_act_on_xfer: assert property (p_act_on_xfer) else $error("active setting moved without transfer");

   property p_narrow_bad;
      r_reg.act_b.mode == `SCPRS_MODE_NARROW && r_reg.act_b.word >= `SCPRS_TW_NARROW_CNT |=> !chan_b_tune_ok;
   endproperty
   a_narrow_bad: assert property (p_narrow_bad) else $error("narrow word out of range accepted");

   property p_wide_range;
      r_reg.act_a.mode == `SCPRS_MODE_WIDE |=> chan_a_tune_ok == ($past(r_reg.act_a.word) < `SCPRS_TW_WIDE_CNT);
   endproperty
   a_wide_range: assert property (p_wide_range) else $error("wide word range wrong");

   property p_left_edge;
      ##1 chan_b_left_edge == {3'h0, $past(r_reg.act_b.word)} * `SCPRS_EDGE_STEP;
   endproperty
   a_left_edge: assert property (p_left_edge) else $error("left edge wrong");

   property p_first_only;
      div_resync && r_reg.act_divsync[`SCPRS_B_SYNC_FIRST] && !$past(r_reg.xfer) |-> !r_reg.armed;
   endproperty
   a_first_only: assert property (p_first_only) else $error("one-shot resync rearmed");

   property p_rise_resync;
      r_reg.act_divsync[`SCPRS_B_SYNC_EN] && !r_reg.act_divsync[`SCPRS_B_SYNC_FIRST]
         && r_reg.act_syncmode[`SCPRS_B_SYNC_EDGE] && !r_reg.act_syncmode[`SCPRS_B_SYNC_FALL]
         && sync_lvl && !r_reg.sync_prev |=> div_resync;
   endproperty
   a_rise_resync: assert property (p_rise_resync) else $error("rising sync missed");

   c_read_drive: cover property ($rose(sdio_oe));
   c_transfer: cover property ($fell(r_reg.xfer));
   c_resync: cover property (div_resync);
   c_stream: cover property (r_reg.stream && r_reg.st == scprs_pkg::scprs_st_data);
endmodule

// ==== design/scprs_consts.svh ====
// Register map, field positions, reset values and counts of the serial config port
`ifndef SCPRS_CONSTS_SVH
`define SCPRS_CONSTS_SVH
`define SCPRS_A_CFG 8'h00
`define SCPRS_A_CHIDX 8'h05
`define SCPRS_A_DIVSYNC 8'h3A
`define SCPRS_A_NSRCTL 8'h3C
`define SCPRS_A_TUNE 8'h3E
`define SCPRS_A_SYNCMODE 8'h59
`define SCPRS_A_XFER 8'hFF
`define SCPRS_XFER_CMD 8'h01
`define SCPRS_RST_CFG 8'h00
`define SCPRS_RST_CHIDX 8'h03
`define SCPRS_B_LSB_FIRST 6
`define SCPRS_B_CH_A 0
`define SCPRS_B_CH_B 1
`define SCPRS_B_SYNC_EN 1
`define SCPRS_B_SYNC_FIRST 2
`define SCPRS_B_SYNC_EDGE 1
`define SCPRS_B_SYNC_FALL 0
`define SCPRS_B_NSR_EN 0
`define SCPRS_F_MODE 3:1
`define SCPRS_F_WORD 5:0
`define SCPRS_MODE_NARROW 3'h0
`define SCPRS_MODE_WIDE 3'h1
`define SCPRS_TW_NARROW_CNT 6'h39
`define SCPRS_TW_WIDE_CNT 6'h22
`define SCPRS_EDGE_STEP 9'h005
`define SCPRS_B_RW 15
`define SCPRS_F_WLEN 14:13
`define SCPRS_F_ADDR 7:0
`define SCPRS_WLEN_STREAM 2'h3
`define SCPRS_INSTR_LAST 4'hF
`define SCPRS_BYTE_LAST 4'h7
`define SCPRS_BIT_TOP 3'h7
`endif

// ==== design/scprs_pkg.sv ====
// Types shared by the serial config port modules
package scprs_pkg;
   typedef enum logic [2:0] {
      scprs_st_idle = 3'h1,
      scprs_st_instr = 3'h2,
      scprs_st_data = 3'h4
   } scprs_st_t;

   // One channel's requantizer setting
   typedef struct packed {
      logic [2:0] mode;
      logic enable;
      logic [5:0] word;
   } scprs_chan_t;

   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
      logic lvl;
   } scprs_sync_t;

   typedef struct packed {
      scprs_st_t st;
      logic sclk_prev;
      logic sync_prev;
      logic seen_frame;
      logic strap_mode;
      logic is_read;
      logic stream;
      logic [1:0] bytes_left;
      logic [3:0] bit_cnt;
      logic [15:0] shift;
      logic [7:0] addr;
      logic [7:0] rd_byte;
      logic sdio_out;
      logic sdio_oe;
      logic [7:0] cfg;
      logic [7:0] chidx;
      logic xfer;
      logic [7:0] sh_divsync;
      logic [7:0] sh_syncmode;
      scprs_chan_t sh_a;
      scprs_chan_t sh_b;
      logic [7:0] act_divsync;
      logic [7:0] act_syncmode;
      scprs_chan_t act_a;
      scprs_chan_t act_b;
      logic armed;
      logic div_resync;
      logic ok_a;
      logic ok_b;
      logic [8:0] edge_a;
      logic [8:0] edge_b;
   } scprs_state_t;
endpackage

// ==== design/scprs_sync3.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module scprs_sync3 #(
   parameter logic RESET_LVL = 1'b0
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   scprs_pkg::scprs_sync_t s_reg;
   scprs_pkg::scprs_sync_t s_next;

   // Level moves only when stages two and three agree; stage one feeds stage two only
   always_comb begin
      s_next = s_reg;
      s_next.ff1 = d;
      s_next.ff2 = s_reg.ff1;
      s_next.ff3 = s_reg.ff2;
      if (s_reg.ff2 == s_reg.ff3) begin
         s_next.lvl = s_reg.ff3;
      end
   end

   // All stages reset to the idle level of the pin
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= {RESET_LVL, RESET_LVL, RESET_LVL, RESET_LVL};
      end else begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.lvl;
endmodule

// ==== dv/scprs_host.sv ====
// Behavioural serial host that drives frames into the config port
`timescale 1ns/10ps
module scprs_host (
   input wire logic ref_clk,
   input wire logic sdio_line,
   output logic spi_sclk,
   output logic chip_select_n,
   output logic sdio_drv,
   output logic sdio_en
);
   logic [7:0] wbuf [0:3];
   logic [7:0] rbuf [0:3];
   logic lsb_first;
   logic pause_between;

   // Lines idle: clock low, select high, data released
   initial begin
      spi_sclk = 1'b0;
      chip_select_n = 1'b1;
      sdio_drv = 1'b0;
      sdio_en = 1'b0;
      lsb_first = 1'b0;
      pause_between = 1'b0;
   end

   // All pin changes land on the falling sample clock edge
   task automatic wait_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Eight cycles each phase, well over the port's filter latency
   task automatic shift_bit(input logic b, input logic drive, output logic got);
      sdio_en = drive;
      sdio_drv = b;
      wait_n(8);
      spi_sclk = 1'b1;
      got = sdio_line;
      wait_n(8);
      spi_sclk = 1'b0;
   endtask

   // Clock pulses with select high; the port must not react
   task automatic stray_clocks(input int n);
      repeat (n) begin
         spi_sclk = 1'b1;
         wait_n(8);
         spi_sclk = 1'b0;
         wait_n(8);
      end
   endtask

   // Whole frame: select low, instruction MSB first, then n data bytes
   task automatic frame(input logic rw, input logic [1:0] wl, input logic [7:0] addr, input int n);
      logic [15:0] instr;
      logic got;
      instr = {rw, wl, 5'h00, addr};
      chip_select_n = 1'b0;
      wait_n(8);
      for (int i = 15; i >= 0; i--) shift_bit(instr[i], 1'b1, got);
      for (int k = 0; k < n; k++) begin
         // Stall between bytes to stretch timing
         if (pause_between && k > 0) begin
            chip_select_n = 1'b1;
            wait_n(12);
            chip_select_n = 1'b0;
            wait_n(8);
         end
         for (int i = 0; i < 8; i++) begin
            shift_bit(wbuf[k][lsb_first ? i : 7 - i], !rw, got);
            rbuf[k][lsb_first ? i : 7 - i] = got;
         end
      end
      sdio_en = 1'b0;
      wait_n(8);
      chip_select_n = 1'b1;
      wait_n(12);
   endtask
endmodule

// ==== dv/serial_config_port_requantizer_sync_bench.sv ====
// Self-checking bench for the serial config port
`timescale 1ns/10ps
module serial_config_port_requantizer_sync_bench;
   logic ref_clk, nrst, sync_in, sdio_o, sdio_oe, strap_mode, idle_pat;
   logic host_sclk, host_cs_n, host_drv, host_en, sdio_line;
   logic chan_a_tune_ok, chan_b_tune_ok, div_resync;
   logic [8:0] chan_a_left_edge, chan_b_left_edge;
   scprs_pkg::scprs_chan_t chan_a_cfg, chan_b_cfg;
   int errors = 0;
   int compares = 0;
   int resync_cnt = 0;
   int clash = 0;
   logic oe_seen = 1'b0;

   // Released data line toggles so a stale value never passes
   assign sdio_line = sdio_oe ? sdio_o : (host_en ? host_drv : idle_pat);

   scprs_top DUT (.ref_clk(ref_clk), .nrst(nrst), .spi_sclk(host_sclk), .chip_select_n(host_cs_n),
      .sdio_i(sdio_line), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sync_in(sync_in), .strap_mode(strap_mode),
      .chan_a_cfg(chan_a_cfg), .chan_b_cfg(chan_b_cfg), .chan_a_tune_ok(chan_a_tune_ok),
      .chan_b_tune_ok(chan_b_tune_ok), .chan_a_left_edge(chan_a_left_edge),
      .chan_b_left_edge(chan_b_left_edge), .div_resync(div_resync));

   scprs_host host (.ref_clk(ref_clk), .sdio_line(sdio_line), .spi_sclk(host_sclk),
      .chip_select_n(host_cs_n), .sdio_drv(host_drv), .sdio_en(host_en));

   always #5 ref_clk = ~ref_clk;

   // Idle pattern, resync pulses and driver contention
   always @(negedge ref_clk) idle_pat <= ~idle_pat;
   // Outputs looked at mid-cycle, away from the edge that launches them
   always @(negedge ref_clk) begin
      if (div_resync === 1'b1) resync_cnt++;
      if (sdio_oe === 1'b1 && host_en === 1'b1) clash++;
      if (sdio_oe === 1'b1) oe_seen = 1'b1;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.wbuf[0] = d;
      host.frame(1'b0, 2'h0, a, 1);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      host.frame(1'b1, 2'h0, a, 1);
      check(what, {8'h00, host.rbuf[0]}, {8'h00, exp});
   endtask

   // Program sync options, commit, pulse the sync pin, count resyncs
   task automatic sync_run(input logic [7:0] ctl, input logic [7:0] mode, input int hi, input int times,
         input int exp);
      wr(8'h3A, ctl);
      wr(8'h59, mode);
      wr(8'hFF, 8'h01);
      resync_cnt = 0;
      repeat (times) begin
         sync_in = 1'b1;
         repeat (hi) @(negedge ref_clk);
         sync_in = 1'b0;
         repeat (12) @(negedge ref_clk);
      end
      check("div_resync count", 16'(resync_cnt), 16'(exp));
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard, about fifty thousand cycles
   initial begin
      #500000;
      errors++;
      give_verdict;
   end

   // Main sequence
   initial begin
      ref_clk = 1'b0;
      idle_pat = 1'b0;
      nrst = 1'b0;
      sync_in = 1'b0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      nrst = 1'b1;
      repeat (6) @(negedge ref_clk);
      check("strap_mode", strap_mode, 1'b1);
      check("sdio_oe idle", sdio_oe, 1'b0);
      host.stray_clocks(3);
      check("strap_mode stray", strap_mode, 1'b1);
      host.pause_between = 1'b1;
      host.frame(1'b1, 2'h1, 8'h05, 2);
      check("chidx reset", {8'h00, host.rbuf[0]}, 16'h0003);
      check("unmapped read", {8'h00, host.rbuf[1]}, 16'h0000);
      host.pause_between = 1'b0;
      check("strap_mode frame", strap_mode, 1'b0);
      rd_chk("syncmode reset", 8'h59, 8'h00);
      // Channel A wide mode, last legal word
      wr(8'h05, 8'h01);
      wr(8'h3C, 8'h03);
      wr(8'h3E, 8'h21);
      check("cfg a shadowed", chan_a_cfg, 16'h0000);
      wr(8'hFF, 8'h01);
      check("cfg a", chan_a_cfg, {6'h00, 3'h1, 1'b1, 6'h21});
      check("cfg b", chan_b_cfg, 16'h0000);
      check("ok a", chan_a_tune_ok, 1'b1);
      check("edge a", chan_a_left_edge, 16'h00A5);
      rd_chk("xfer clear", 8'hFF, 8'h00);
      wr(8'h3E, 8'h22);
      wr(8'hFF, 8'h01);
      check("ok a over", chan_a_tune_ok, 1'b0);
      check("edge a over", chan_a_left_edge, 16'h00AA);
      // Channel B narrow mode, both sides of the limit
      wr(8'h05, 8'h02);
      wr(8'h3C, 8'h01);
      wr(8'h3E, 8'h38);
      wr(8'hFF, 8'h01);
      check("cfg b", chan_b_cfg, {6'h00, 3'h0, 1'b1, 6'h38});
      check("ok b", chan_b_tune_ok, 1'b1);
      check("cfg a kept", chan_a_cfg, {6'h00, 3'h1, 1'b1, 6'h22});
      wr(8'h3E, 8'h39);
      wr(8'hFF, 8'h01);
      check("ok b over", chan_b_tune_ok, 1'b0);
      check("edge b", chan_b_left_edge, 16'h011D);
      wr(8'h05, 8'h03);
      rd_chk("both read a", 8'h3E, 8'h22);
      // Streamed write walks the address down until select rises
      host.wbuf[0] = 8'h11;
      host.wbuf[1] = 8'hAA;
      host.wbuf[2] = 8'h03;
      host.frame(1'b0, 2'h3, 8'h3E, 3);
      rd_chk("stream tune", 8'h3E, 8'h11);
      rd_chk("stream ctl", 8'h3C, 8'h03);
      // Bit order: a known value read back reversed if ignored
      wr(8'h00, 8'h40);
      host.lsb_first = 1'b1;
      rd_chk("lsb read", 8'h05, 8'h03);
      wr(8'h00, 8'h00);
      host.lsb_first = 1'b0;
      rd_chk("msb read", 8'h05, 8'h03);
      // Sync: rising, falling, level, first only, disabled
      sync_run(8'h02, 8'h02, 10, 1, 1);
      sync_run(8'h02, 8'h03, 10, 1, 1);
      sync_run(8'h02, 8'h00, 10, 1, 10);
      sync_run(8'h06, 8'h02, 10, 2, 1);
      sync_run(8'h00, 8'h02, 10, 1, 0);
      check("no contention", 16'(clash), 16'h0000);
      check("readback drove", oe_seen, 1'b1);
      give_verdict;
   end
endmodule
